// ### logic/gdm_core.sv
// Purpose: remote/local/lockout control, clear and trigger handling,
//          measurement sequencing and result string output
// Assumes: bus commands decoded outside; measuring engine outside
// Notes:   settings reachable over a plain register port
`timescale 1ns/1ps
module gdm_core #(
  parameter int unsigned SETTLE_NS      = 100000,
  parameter logic [7:0]  ERR_RANGE_CODE = 8'h01
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // bus commands and levels
  input  wire gdm_pkg::gdm_cmd_s cmd,
  input  wire gdm_pkg::gdm_bus_s bus,
  // program trigger codes
  input  wire logic              prog_valid,
  input  wire gdm_pkg::gdm_trig_e prog_code,
  // front-panel keys, one-cycle pulses
  input  wire logic              local_key,
  input  wire logic              clear_key,
  // measuring engine
  output logic                   meas_go,
  output logic                   meas_settled,
  input  wire logic              meas_done,
  input  wire gdm_pkg::gdm_res_s meas_res,
  // source handshake for result bytes
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  output logic                   tx_last,
  input  wire logic              tx_ready,
  // service request side
  output logic                   srq_clr,
  output logic                   stb_clr,
  // lamps and key disables
  output gdm_pkg::gdm_ind_s      ind,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata
);
  import gdm_pkg::*;

  localparam int unsigned SETTLE_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int unsigned CW         = $clog2(SETTLE_CYC + 1);

  typedef struct packed {
    logic           rem;
    logic           lock;
    logic           lstn_p;
    logic           adr;
    gdm_trig_e      trig;
    gdm_ph_e        ph;
    logic           settled;
    logic [CW-1:0]  cnt;
    gdm_res_s       res;
    logic [3:0]     pos;
    logic [7:0]     txd;
    logic [31:0]    start;
    logic [31:0]    stop;
    logic [31:0]    freq;
    logic [31:0]    step;
    gdm_ctrl_s      ctrl;
    logic [31:0]    rdata;
    logic           go;
    logic           srq_clr;
    logic           stb_clr;
  } gdm_st_s;

  localparam gdm_ctrl_s CTRL_DEF = '{
    rsvd:       21'h0,
    srq_cond:   SRQ_COND_DEF,
    read_right: 1'b1,
    log_scale:  1'b0,
    ratio:      1'b0,
    hpbp:       HPBP_OFF,
    lp80:       1'b1,
    meas_fn:    MEAS_AC
  };

  gdm_st_s   q;
  gdm_st_s   d;
  logic      clr;
  logic      lstn_rise;
  logic      keys_live;
  logic      go_settle;
  logic      go_imm;
  logic      tx_fire;
  logic      ld;
  logic      adv;
  gdm_trig_e eff;
  gdm_res_s  fmt_res;
  logic [3:0] fmt_pos;
  logic [7:0] fmt_byte;

  // handshake outputs are combinational from state and the talk level
  assign tx_valid = (q.ph == PH_SEND) && bus.tlk;
  assign tx_fire  = tx_valid && tx_ready;
  assign tx_data  = q.txd;
  assign tx_last  = tx_valid && (q.pos == POS_LF);

  // string position advance; byte registered one cycle ahead of offer
  assign ld      = (q.ph == PH_MEAS) && meas_done;
  assign adv     = tx_fire && (q.pos != POS_LF);
  assign fmt_res = ld ? meas_res : q.res;
  assign fmt_pos = ld ? POS_SIGN : (adv ? q.pos + 4'h1 : q.pos);

  gdm_fmt #(
    .ERR_RANGE_CODE (ERR_RANGE_CODE)
  ) u_fmt (
    .res    (fmt_res),
    .pos    (fmt_pos),
    .byte_o (fmt_byte)
  );

  // next-state logic
  always_comb begin
    d         = q;
    d.go      = 1'b0;
    d.srq_clr = 1'b0;
    d.stb_clr = 1'b0;
    d.rdata   = 32'h0;
    d.res     = fmt_res;
    d.pos     = fmt_pos;
    d.txd     = fmt_byte;
    d.lstn_p  = bus.lstn;
    d.adr     = bus.lstn | bus.tlk;
    go_settle = 1'b0;
    go_imm    = 1'b0;
    clr       = cmd.dcl | (cmd.sdc & bus.lstn);
    lstn_rise = bus.lstn & ~q.lstn_p;
    keys_live = q.rem & ~q.lock;
    eff       = q.rem ? q.trig : TRIG_FREE;  // local always runs free

    // software writes to settings
    if (reg_wr) begin
      case (reg_addr)
        REG_START: d.start = reg_wdata;
        REG_STOP:  d.stop  = reg_wdata;
        REG_FREQ:  d.freq  = reg_wdata;
        REG_STEP:  d.step  = reg_wdata;
        REG_CTRL:  d.ctrl  = gdm_ctrl_s'({22'h0, reg_wdata[9:0]});
        default:   d.ctrl  = d.ctrl;
      endcase
    end

    // read data stand only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        REG_START: d.rdata = q.start;
        REG_STOP:  d.rdata = q.stop;
        REG_FREQ:  d.rdata = q.freq;
        REG_STEP:  d.rdata = q.step;
        REG_CTRL:  d.rdata = q.ctrl;
        REG_STAT:  d.rdata = {24'h0, q.ph, q.trig, bus.ren, q.adr, q.lock, q.rem};
        default:   d.rdata = 32'h0;
      endcase
    end

    // remote/local state; of the settings only trig is touched here, set to free run on remote entry
    if (!bus.ren || !bus.attached) begin
      d.rem  = 1'b0;
      d.lock = 1'b0;
    end else begin
      if (cmd.llo) begin
        d.lock = 1'b1;  // armed in local too
      end
      if (lstn_rise && !q.rem) begin
        d.rem  = 1'b1;
        d.trig = TRIG_FREE;
      end
      if (cmd.gtl && bus.lstn) begin
        d.rem = 1'b0;  // lockout stays armed
      end
      if (local_key && keys_live) begin
        d.rem = 1'b0;  // keys never release a lockout
      end
    end

    // trigger sources
    if (cmd.get && q.rem && bus.lstn) begin
      go_settle = 1'b1;
    end
    if (clear_key && keys_live) begin
      go_settle = 1'b1;
    end
    if (prog_valid && q.rem && bus.lstn) begin
      d.trig = prog_code;
      if (prog_code == TRIG_SETTLED) begin
        go_settle = 1'b1;
      end
      if (prog_code == TRIG_IMMED) begin
        go_imm = 1'b1;
      end
    end
    // take-control is not decoded at all: no controller function

    // clear restores the fixed default state
    if (clr) begin
      d.start   = START_DEF;
      d.stop    = STOP_DEF;
      d.freq    = FREQ_DEF;
      d.step    = STEP_DEF;
      d.ctrl    = CTRL_DEF;
      d.trig    = TRIG_FREE;
      d.lock    = 1'b0;
      d.srq_clr = 1'b1;
      d.stb_clr = 1'b1;
    end

    // measurement sequencer; a new trigger restarts any cycle in progress
    if (go_settle) begin
      d.ph      = PH_SETTLE;
      d.settled = 1'b1;
      d.cnt     = CW'(SETTLE_CYC - 1);
    end else if (go_imm) begin
      d.ph      = PH_MEAS;
      d.settled = 1'b0;
      d.go      = 1'b1;
    end else if (clr || (prog_valid && q.rem && bus.lstn)) begin
      d.ph = PH_IDLE;  // mode change: start over from idle
    end else begin
      case (q.ph)
        PH_IDLE: begin
          if (eff == TRIG_FREE) begin
            d.ph      = PH_MEAS;
            d.settled = 1'b0;
            d.go      = 1'b1;
          end
        end
        PH_SETTLE: begin
          if (q.cnt == '0) begin
            d.ph = PH_MEAS;
            d.go = 1'b1;
          end else begin
            d.cnt = q.cnt - CW'(1);
          end
        end
        PH_MEAS: begin
          if (meas_done) begin
            d.ph = PH_SEND;
          end
        end
        PH_SEND: begin
          if (tx_fire && q.pos == POS_LF) begin
            d.ph = PH_IDLE;  // LF closes the string
          end else if (eff == TRIG_FREE && !bus.tlk && q.pos == POS_SIGN) begin
            d.ph = PH_IDLE;  // nobody reading: free run measures again
          end
        end
        default: d.ph = PH_IDLE;
      endcase
    end
  end

  // state register; power cycle is the reset, which also frees a lockout
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.trig    <= TRIG_FREE;
      q.ph      <= PH_IDLE;
      q.start   <= START_DEF;
      q.stop    <= STOP_DEF;
      q.freq    <= FREQ_DEF;
      q.step    <= STEP_DEF;
      q.ctrl    <= CTRL_DEF;
      q.res     <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign meas_go           = q.go;
  assign meas_settled      = q.settled;
  assign srq_clr           = q.srq_clr;
  assign stb_clr           = q.stb_clr;
  assign reg_rdata         = q.rdata;
  assign ind.remote        = q.rem;
  assign ind.addressed     = q.adr;
  assign ind.local_key_off = q.rem & q.lock;
  assign ind.clear_key_off = q.rem & q.lock;

endmodule // gdm_core

// ### logic/gdm_fmt.sv
// Purpose: picks one byte of the twelve-byte result string
// Assumes: result held stable while the string is sent
// Notes:   out-of-range values are reported as an error string
`timescale 1ns/1ps
module gdm_fmt #(
  parameter logic [7:0] ERR_RANGE_CODE = 8'h01
) (
  // source
  input  wire gdm_pkg::gdm_res_s res,
  input  wire logic [3:0]        pos,
  // byte out
  output logic [7:0]             byte_o
);
  import gdm_pkg::*;

  logic [63:0] mant;
  logic [63:0] scale;
  logic        over;
  logic [4:0][3:0] dg;
  logic [7:0]  ecode;
  logic        is_err;

  // magnitude check against the largest legal value
  always_comb begin
    mant = 64'(res.dig[4]) * 64'h2710 + 64'(res.dig[3]) * 64'h3e8
         + 64'(res.dig[2]) * 64'h64 + 64'(res.dig[1]) * 64'ha + 64'(res.dig[0]);
    scale = 64'h1;
    for (int i = 0; i < 10; i++) begin
      if (4'(i) < res.expo[0]) begin
        scale = scale * 64'ha;
      end
    end
    over = 1'b0;
    if (!res.exp_neg && mant != 64'h0) begin
      if (res.expo[1] != 4'h0 || mant * scale > MAG_MAX) begin
        over = 1'b1;
      end
    end
  end

  // error strings force +900ccE+05, code recovered as (v - 9e9) / 1e5
  always_comb begin
    is_err = res.err | over;
    ecode  = res.err ? {res.code[1], res.code[0]} : ERR_RANGE_CODE;
    dg     = is_err ? {ERR_D9, ERR_D0, ERR_D0, ecode[7:4], ecode[3:0]} : res.dig;
    byte_o = CH_ZERO;
    case (pos)
      POS_SIGN: byte_o = (res.neg && !is_err) ? CH_MINUS : CH_PLUS;
      POS_E:    byte_o = CH_E;
      POS_ESGN: byte_o = (res.exp_neg && !is_err) ? CH_MINUS : CH_PLUS;
      POS_EHI:  byte_o = CH_ZERO | 8'(is_err ? ERR_EXP[7:4] : res.expo[1]);
      POS_ELO:  byte_o = CH_ZERO | 8'(is_err ? ERR_EXP[3:0] : res.expo[0]);
      POS_CR:   byte_o = CH_CR;
      POS_LF:   byte_o = CH_LF;
      default: begin
        if (pos >= POS_DIG0 && pos < POS_E) begin
          byte_o = CH_ZERO | 8'(dg[3'(POS_E - pos - 4'h1)]);  // leading zeros kept
        end
      end
    endcase
  end

endmodule // gdm_fmt

// ### pkg/gdm_pkg.sv
// Purpose: shared types and constants of the bus message handler
// Assumes: bus commands arrive decoded as one-cycle pulses on clock
// Notes:   frequencies are held in units of 0.1 Hz
// Function
// - result bytes: sign, five digits, E, signed exponent, then CR and LF
// - values in base units, decimal point after fifth digit, at most 4e9
// - errors use the same layout, +900ccE+05, code in last two digits
// - selected clear counts only when listening; universal clear always counts
// - a clear drops pending service request, condition becomes code error only
// - a clear loads sweep, frequency, step, level measurement, filter defaults
// - a clear clears status, reads right display, free run, no lockout, linear
// - group trigger in remote and listening runs one settled cycle
// - remote enabled by REN, remote entered at first listen addressing
// - entering remote forces free run only; remote lamp lit while remote
// - addressed lamp lit whenever addressed, remote or local
// - go-to-local while listening returns local, keeps lockout armed
// - remote to local changes no settings; local runs free; lamp off
// - lockout in remote disables local and clear keys; else clear triggers in remote only
// - lockout received in local with REN applies at first listen addressing
// - lockout released only by controller, power cycle or cable loss
// - REN false returns local, drops lockout, remote lamp off
// - take-control and pass control are ignored entirely
// - settled trigger waits a settling delay before measuring
package gdm_pkg;

  localparam int unsigned CLK_NS = 8;  // 125 MHz

  typedef enum logic [1:0] {TRIG_FREE, TRIG_HOLD, TRIG_IMMED, TRIG_SETTLED} gdm_trig_e;
  typedef enum logic [1:0] {MEAS_AC, MEAS_SINAD, MEAS_DIST, MEAS_DC} gdm_meas_e;
  typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_MEAS, PH_SEND} gdm_ph_e;

  // measurement result as handed over by the measuring engine
  typedef struct packed {
    logic            neg;
    logic [4:0][3:0] dig;      // bcd, dig[4] most significant
    logic            exp_neg;
    logic [1:0][3:0] expo;     // bcd exponent
    logic            err;
    logic [1:0][3:0] code;     // bcd error code
  } gdm_res_s;

  // decoded bus commands, one-cycle pulses
  typedef struct packed {
    logic dcl;
    logic sdc;
    logic get;
    logic gtl;
    logic llo;
  } gdm_cmd_s;

  // bus levels
  typedef struct packed {
    logic ren;
    logic lstn;
    logic tlk;
    logic attached;
  } gdm_bus_s;

  // front-panel lamps and key disables
  typedef struct packed {
    logic remote;
    logic addressed;
    logic local_key_off;
    logic clear_key_off;
  } gdm_ind_s;

  // settings word
  typedef struct packed {
    logic [20:0] rsvd;         // pads the word to 32 bits
    logic [2:0]  srq_cond;     // bit0 data ready, bit1 code error, bit2 instr error
    logic        read_right;
    logic        log_scale;
    logic        ratio;
    logic [1:0]  hpbp;
    logic        lp80;
    gdm_meas_e   meas_fn;
  } gdm_ctrl_s;

  // register byte addresses
  localparam logic [7:0] REG_START = 8'h00;
  localparam logic [7:0] REG_STOP  = 8'h04;
  localparam logic [7:0] REG_FREQ  = 8'h08;
  localparam logic [7:0] REG_STEP  = 8'h0c;
  localparam logic [7:0] REG_CTRL  = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;

  // defaults loaded by a clear
  localparam logic [31:0] START_DEF = 32'h0000_00c8;  // 20 Hz
  localparam logic [31:0] STOP_DEF  = 32'h0003_0d40;  // 20 kHz
  localparam logic [31:0] FREQ_DEF  = 32'h0000_2710;  // 1000.0 Hz
  localparam logic [31:0] STEP_DEF  = 32'h0000_2710;  // 1000.0 Hz
  localparam logic [2:0]  SRQ_COND_DEF = 3'h2;
  localparam logic [1:0]  HPBP_OFF  = 2'h0;

  // output string
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [3:0] POS_SIGN = 4'h0;
  localparam logic [3:0] POS_DIG0 = 4'h1;
  localparam logic [3:0] POS_E    = 4'h6;
  localparam logic [3:0] POS_ESGN = 4'h7;
  localparam logic [3:0] POS_EHI  = 4'h8;
  localparam logic [3:0] POS_ELO  = 4'h9;
  localparam logic [3:0] POS_CR   = 4'ha;
  localparam logic [3:0] POS_LF   = 4'hb;
  localparam logic [3:0] ERR_D9   = 4'h9;
  localparam logic [3:0] ERR_D0   = 4'h0;
  localparam logic [7:0] ERR_EXP  = 8'h05;
  localparam logic [63:0] MAG_MAX = 64'h0000_0000_ee6b_2800;  // 4 000 000 000

endpackage : gdm_pkg

// ### test/gdm_core_assertions.sv
// Purpose: port checks for the message handler core
// Assumes: one clock domain, bus commands are one-cycle pulses
// Notes:   settle window is derived from SETTLE_NS and the clock period
`timescale 1ns/1ps
module gdm_core_assertions #(
  parameter int unsigned SETTLE_NS = 100000
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // bus side
  input  wire gdm_pkg::gdm_cmd_s cmd,
  input  wire gdm_pkg::gdm_bus_s bus,
  input  wire logic              prog_valid,
  input  wire logic              clear_key,
  input  wire logic              meas_go,
  // result bytes
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_last,
  input  wire logic              tx_ready,
  // clear pulses and lamps
  input  wire logic              srq_clr,
  input  wire logic              stb_clr,
  input  wire gdm_pkg::gdm_ind_s ind
);
  import gdm_pkg::*;
  localparam int unsigned SETTLE_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned W_GO       = ((SETTLE_RAW < 1) ? 1 : SETTLE_RAW) + 1;

  logic [31:0] wait_q;  // edges since a settled trigger, 0 when not watching
  logic        trig_settle;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  assign trig_settle = cmd.get && ind.remote && bus.lstn && bus.ren;

  // a counter, since the settle span is far beyond any delay range;
  // other triggers and clears restart the sequencer, so the watch is dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 32'h0;
    end else if (trig_settle) begin
      wait_q <= 32'h1;
    end else if (prog_valid || clear_key || cmd.dcl || cmd.sdc || meas_go) begin
      wait_q <= 32'h0;
    end else if (wait_q != 32'h0) begin
      wait_q <= wait_q + 32'h1;
    end
  end

  // the settled start is a single pulse
  sequence s_go_pulse;
    meas_go ##1 !meas_go;
  endsequence

  settle_wait_a: assert property (
    wait_q != 32'h0 && wait_q < W_GO |-> !meas_go)
    else $error("settled trigger started early");
  settle_go_a: assert property (
    wait_q == W_GO && !prog_valid |-> s_go_pulse)
    else $error("settled trigger start missing");
  clear_pulse_a: assert property (cmd.dcl |=> srq_clr && stb_clr)
    else $error("clear without pulses");
  sdc_listen_a: assert property (
    cmd.sdc && !bus.lstn && !cmd.dcl |=> !srq_clr)
    else $error("selected clear taken while unaddressed");
  ren_drop_a: assert property (
    !bus.ren |=> !ind.remote && !ind.local_key_off)
    else $error("remote kept without ren");
  addr_lamp_a: assert property (
    bus.attached && (bus.lstn || bus.tlk) |=> ind.addressed)
    else $error("addressed lamp dark");
  talk_only_a: assert property (tx_valid |-> bus.tlk)
    else $error("byte offered while not talker");
  hold_byte_a: assert property (
    tx_valid && !tx_ready && cmd == '0 && !prog_valid && !clear_key |=> $stable(tx_data))
    else $error("byte changed before acceptance");
  last_lf_a: assert property (tx_valid |-> tx_last == (tx_data == CH_LF))
    else $error("last flag not on line feed");
  lock_keys_a: assert property (
    cmd.llo && bus.ren && ind.remote && !cmd.gtl |=> ind.local_key_off && ind.clear_key_off)
    else $error("lockout left keys live");
  lock_stay_a: assert property (
    ind.remote && ind.local_key_off && bus.ren && bus.attached && cmd == '0 |=> ind.remote)
    else $error("lockout released without controller");
endmodule // gdm_core_assertions

bind gdm_core gdm_core_assertions #(.SETTLE_NS(SETTLE_NS)) u_chk (
  .clock, .rst_n, .cmd, .bus, .prog_valid, .clear_key, .meas_go, .tx_valid,
  .tx_data, .tx_last, .tx_ready, .srq_clr, .stb_clr, .ind);

// ### test/gdm_core_tb.sv
// Purpose: self-checking bench for the message handler core
// Assumes: engine stand-in answers four cycles after each start
// Notes:   short settle parameter keeps the run to a few hundred cycles
`timescale 1ns/1ps
module gdm_core_tb;
  import gdm_pkg::*;
  localparam int unsigned SNS = 80;
  localparam int          SC  = SNS / CLK_NS;
  localparam gdm_cmd_s C_DCL = 5'h10;
  localparam gdm_cmd_s C_SDC = 5'h08;
  localparam gdm_cmd_s C_GET = 5'h04;
  localparam gdm_cmd_s C_GTL = 5'h02;
  localparam gdm_cmd_s C_LLO = 5'h01;
  logic        clock, rst_n, prog_valid, local_key, clear_key, meas_go, meas_done, meas_settled;
  logic        tx_valid, tx_last, tx_ready, reg_wr, reg_rd, srq_clr, stb_clr;
  logic [7:0]  tx_data, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0]  eng_q;
  gdm_cmd_s    cmd;
  gdm_bus_s    bus;
  gdm_ind_s    ind;
  gdm_trig_e   prog_code;
  gdm_res_s    res;
  int          failures, checked;

  gdm_core #(.SETTLE_NS(SNS)) dut (.clock, .rst_n, .cmd, .bus, .prog_valid, .prog_code,
    .local_key, .clear_key, .meas_go, .meas_settled, .meas_done, .meas_res(res),
    .tx_valid, .tx_data, .tx_last, .tx_ready, .srq_clr, .stb_clr, .ind, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  gdm_ctl_model ctl (.clock, .cmd, .bus, .tx_ready, .tx_valid, .tx_data);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // engine stand-in: a result four cycles after each start
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eng_q     <= 3'h0;
      meas_done <= 1'b0;
    end else begin
      eng_q     <= {eng_q[1:0], meas_go};
      meas_done <= eng_q[2];
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic t_regs;
    logic [7:0]  ad[4] = '{REG_START, REG_STOP, REG_FREQ, REG_STEP};
    logic [31:0] ex[4] = '{START_DEF, STOP_DEF, FREQ_DEF, STEP_DEF};
    wr(REG_FREQ, 32'h0000_04d2);
    wr(REG_CTRL, 32'h0000_0079);
    rd(REG_FREQ);
    chk("freq written", 32'h0000_04d2, d);
    rd(8'h20);
    chk("unmapped", 32'h0, d);
    ctl.pulse(C_DCL);
    chk("clear pulses", 32'h3, {srq_clr, stb_clr});
    for (int i = 0; i < 4; i++) begin
      rd(ad[i]);
      chk("default", ex[i], d);
    end
    rd(REG_CTRL);
    chk("ctrl default", 32'h0000_0284, d);
  endtask

  task automatic t_remote;
    ctl.pulse(C_SDC);
    chk("sdc unaddressed", 32'h0, srq_clr);
    ctl.lvl(1'b1, 1'b0, 1'b0);
    chk("ren only", 32'h0, ind);
    ctl.lvl(1'b1, 1'b1, 1'b0);
    chk("remote lamps", 32'hc, ind);
    rd(REG_STAT);
    chk("trig free", 32'h0, d[5:4]);
    ctl.pulse(C_LLO);
    chk("lockout lamps", 32'hf, ind);
    @(posedge clock);
    local_key <= 1'b1;
    clear_key <= 1'b1;
    @(posedge clock);
    local_key <= 1'b0;
    clear_key <= 1'b0;
    @(posedge clock);
    #1 chk("keys ignored", 32'hf, ind);
    ctl.pulse(C_GTL);
    chk("gtl local", 32'h1, {ind.remote, ind.addressed});
    rd(REG_STAT);
    chk("lock kept", 32'h1, d[1]);
    ctl.lvl(1'b1, 1'b0, 1'b0);
    ctl.lvl(1'b1, 1'b1, 1'b0);
    chk("relocked", 32'hf, ind);
    ctl.pulse(C_SDC);
    chk("sdc clears", 32'h19, {ind, srq_clr});
    ctl.lvl(1'b0, 1'b1, 1'b0);
    chk("ren off", 32'h4, ind);
    ctl.lvl(1'b1, 1'b0, 1'b0);
    ctl.pulse(C_LLO);
    chk("armed local", 32'h0, ind.remote);
    ctl.lvl(1'b1, 1'b1, 1'b0);
    chk("lockout entry", 32'hf, ind);
    ctl.lvl(1'b0, 1'b0, 1'b0);
  endtask

  // get, settled code, get, then an immediate over-range value; odd passes stall
  task automatic t_trig;
    gdm_res_s rv[4] = '{{1'b0, 20'h12345, 1'b0, 8'h03, 1'b0, 8'h00},
                        {1'b1, 20'h00070, 1'b1, 8'h06, 1'b0, 8'h00},
                        {1'b0, 20'h00000, 1'b0, 8'h00, 1'b1, 8'h31},
                        {1'b0, 20'h50000, 1'b0, 8'h05, 1'b0, 8'h00}};
    string    sv[4] = '{"+12345E+03", "-00070E-06", "+90031E+05", "+90001E+05"};
    int       n;
    ctl.lvl(1'b1, 1'b0, 1'b0);
    ctl.pulse(C_LLO);
    ctl.lvl(1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      res = rv[k];
      ctl.slow = k[0];
      if (k[0]) begin
        @(posedge clock);
        prog_valid <= 1'b1;
        prog_code  <= (k == 1) ? TRIG_SETTLED : TRIG_IMMED;
        @(posedge clock);
        prog_valid <= 1'b0;
        #1;
      end else ctl.pulse(C_GET);
      ctl.got.delete();
      n = 0;
      // look after the edge, so the start pulse is seen where it stands
      while (meas_go !== 1'b1 && n < 100) begin
        @(posedge clock);
        #1 n++;
      end
      chk("settle delay", (k == 3) ? 0 : SC, n);
      chk("settled start", (k == 3) ? 0 : 1, meas_settled);
      n = 0;
      while (ctl.got.size() < 12 && n < 200) begin
        @(posedge clock);
        n++;
      end
      for (int i = 0; i < 12; i++)
        chk("result byte", i < 10 ? sv[k][i] : (i == 10 ? CH_CR : CH_LF), ctl.got[i]);
    end
    ctl.lvl(1'b0, 1'b0, 1'b0);
  endtask

  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // the tests need a few hundred cycles; twenty thousand means a hang
  initial begin
    #160000;
    failures++;
    report_and_stop;
  end

  initial begin
    rst_n      = 1'b0;
    prog_valid = 1'b0;
    prog_code  = TRIG_FREE;
    local_key  = 1'b0;
    clear_key  = 1'b0;
    res        = '0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    failures   = 0;
    checked    = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_remote;
    t_trig;
    report_and_stop;
  end
endmodule // gdm_core_tb

// ### test/gdm_ctl_model.sv
// Purpose: behavioural bus controller facing the message handler
// Assumes: commands are issued one at a time
// Notes:   slow mode drops ready every other cycle to stall the source
`timescale 1ns/1ps
module gdm_ctl_model (
  // clock
  input  wire logic              clock,
  // commands and bus levels
  output gdm_pkg::gdm_cmd_s      cmd,
  output gdm_pkg::gdm_bus_s      bus,
  // source handshake
  output logic                   tx_ready,
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_data
);
  import gdm_pkg::*;
  logic [7:0] got[$];
  logic       slow = 1'b0;

  // cable attached, nothing else asserted
  initial begin
    cmd      = '0;
    bus      = 4'h1;
    tx_ready = 1'b0;
  end

  // a byte counts only on an edge that sees valid and ready together
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // one command held for exactly one clock
  task automatic pulse(input gdm_cmd_s c);
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    cmd <= '0;
    #1;
  endtask

  // callers raise ren on its own before the listen address follows
  task automatic lvl(input logic r, input logic l, input logic t);
    @(posedge clock);
    bus <= {r, l, t, 1'b1};
    @(posedge clock);
    #1;
  endtask
endmodule // gdm_ctl_model
